//--- hw/ims_pkg.sv
// Constants shared by the event sequencer, its port checker and the device model
package ims_pkg;
	// Register indices on the device register port
	localparam logic [1:0] REG_CR  = 2'h0;
	localparam logic [1:0] REG_SR1 = 2'h1;
	localparam logic [1:0] REG_SR2 = 2'h2;
	localparam logic [1:0] REG_DR  = 2'h3;
	// Control register fields
	localparam int CR_PE    = 5;
	localparam int CR_START = 3;
	localparam int CR_ACK   = 2;
	localparam int CR_STOP  = 1;
	localparam int CR_ITE   = 0;
	localparam logic [7:0] CR_RST = 8'h00;
	// Status one register fields
	localparam int SR1_EVF  = 7;
	localparam int SR1_BUSY = 4;
	localparam int SR1_BTF  = 3;
	localparam int SR1_MSL  = 1;
	localparam int SR1_SB   = 0;
	// Status two register fields
	localparam int SR2_AF   = 4;
	localparam int SR2_ARBITRATION_LOST_FLAG = 2;
	localparam int SR2_BUS_ERROR_FLAG = 1;
	// Poll interval
	localparam int CLK_PERIOD_NS = 5;
	localparam int POLL_NS       = 1000;
	localparam int POLL_CYC      = POLL_NS / CLK_PERIOD_NS;
	// Transfer phases
	typedef enum logic [1:0] {
		PH_START,
		PH_ADDR,
		PH_DATA,
		PH_END
	} ims_phase_t;
endpackage : ims_pkg

//--- hw/ims_stream_if.sv
// Valid/ready byte stream between sequencer and FIFOs
`timescale 1ns/100ps
interface ims_stream_if #(parameter int W = 8);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : ims_stream_if

//--- hw/ims_fifo.sv
// Synchronous FIFO with registered full and empty flags
`timescale 1ns/100ps
module ims_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input wire logic      clock,
	input wire logic      rstn,
	ims_stream_if.snk     in_s,
	ims_stream_if.src     out_s
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   count;
	logic          full;
	logic          empty;
	wire           push = in_s.valid && !full;
	wire           pop  = out_s.ready && !empty;
	wire [AW:0]    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

	// Handshake flags straight from flops
	assign in_s.ready  = !full;
	assign out_s.valid = !empty;
	assign out_s.data  = mem[rp];

	////////////////////////////////////////////////////////////////////////
	// Storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wp] <= in_s.data;
		end
	end

	// Pointers and flags
	always_ff @(posedge clock) begin
		if (!rstn) begin
			wp    <= '0;
			rp    <= '0;
			count <= '0;
			full  <= 1'b0;
			empty <= 1'b1;
		end else begin
			wp    <= push ? AW'(wp + 1'b1) : wp;
			rp    <= pop ? AW'(rp + 1'b1) : rp;
			count <= next_count;
			full  <= (next_count == (AW+1)'(DEPTH));
			empty <= (next_count == '0);
		end
	end
endmodule : ims_fifo

//--- hw/ims_master_seq.sv
// Host sequencer driving the I2C interface registers for master transfers
`timescale 1ns/100ps
module ims_master_seq #(
	parameter int LW = 8
) (
	input  wire logic          clock,
	input  wire logic          rstn,
	// User command port
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	input  wire logic          cmd_read,
	input  wire logic [6:0]    cmd_addr,
	input  wire logic [LW-1:0] cmd_len,
	input  wire logic          tx_valid,
	output logic               tx_ready,
	input  wire logic [7:0]    tx_data,
	output logic               rx_valid,
	input  wire logic          rx_ready,
	output logic [7:0]         rx_data,
	output logic               done,
	output logic [2:0]         done_err,
	// Device register port
	output logic [1:0]         reg_addr,
	output logic               reg_wr,
	output logic               reg_rd,
	output logic [7:0]         reg_wdata,
	input  wire logic [7:0]    reg_rdata,
	input  wire logic          dev_irq
);
	typedef enum logic [4:0] {
		IDLE, EN1, EN2, BUSY_RD, BUSY_CHK, START, POLL_WAIT, POLL_CHK, SR2_RD, SR2_CHK,
		ADDR_WR, EV6_RD, EV6_WR, TX_RD, TX_WR, TX_STOP, RX_CR, RX_RD, RX_CAP,
		REL_SET, REL_CLR, END_WAIT, END_CHK, DONE
	} ims_state_t;

	ims_state_t         state;
	ims_pkg::ims_phase_t phase;
	logic               rd_mode;
	logic [6:0]         addr;
	logic [LW-1:0]      rem;
	logic               irq_m;
	logic               irq_s;
	logic [15:0]        poll_cnt;
	logic               poll_tick;

	ims_stream_if #(.W(8)) tx_in ();
	ims_stream_if #(.W(8)) tx_out ();
	ims_stream_if #(.W(8)) rx_in ();
	ims_stream_if #(.W(8)) rx_out ();

	// Control register images
	wire [7:0] cr_pe    = 8'h01 << ims_pkg::CR_PE;
	wire [7:0] cr_base  = cr_pe | (8'h01 << ims_pkg::CR_ITE);
	wire [7:0] cr_ack   = 8'h01 << ims_pkg::CR_ACK;
	wire [7:0] cr_start = 8'h01 << ims_pkg::CR_START;
	wire [7:0] cr_stop  = 8'h01 << ims_pkg::CR_STOP;

	// Status decode of the word returned after a read
	wire event_flag   = reg_rdata[ims_pkg::SR1_EVF];
	wire sb    = reg_rdata[ims_pkg::SR1_SB];
	wire byte_finished_flag   = reg_rdata[ims_pkg::SR1_BTF];
	wire busy  = reg_rdata[ims_pkg::SR1_BUSY];
	wire msl   = reg_rdata[ims_pkg::SR1_MSL];
	wire [2:0] errs = {reg_rdata[ims_pkg::SR2_AF], reg_rdata[ims_pkg::SR2_BUS_ERROR_FLAG], reg_rdata[ims_pkg::SR2_ARBITRATION_LOST_FLAG]};
	wire last_rx = (rem == LW'(1));
	wire rem_two = (rem == LW'(2));

	// FIFO hookup
	assign tx_in.valid  = tx_valid;
	assign tx_in.data   = tx_data;
	assign tx_ready     = tx_in.ready;
	assign tx_out.ready = (state == TX_WR) && tx_out.valid;
	assign rx_in.valid  = (state == RX_CAP);
	assign rx_in.data   = reg_rdata;
	assign rx_valid     = rx_out.valid;
	assign rx_data      = rx_out.data;
	assign rx_out.ready = rx_ready;

	ims_fifo #(.W(8), .DEPTH(16)) u_tx_fifo (
		.clock (clock),
		.rstn  (rstn),
		.in_s  (tx_in),
		.out_s (tx_out)
	);

	ims_fifo #(.W(8), .DEPTH(16)) u_rx_fifo (
		.clock (clock),
		.rstn  (rstn),
		.in_s  (rx_in),
		.out_s (rx_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin synchroniser, the device request is gated by its enable
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_m <= 1'b0;
			irq_s <= 1'b0;
		end else begin
			irq_m <= dev_irq;
			irq_s <= irq_m;
		end
	end

	// Poll divider, a fallback beside the interrupt in POLL_WAIT and the only wake-up in END_WAIT
	always_ff @(posedge clock) begin
		if (!rstn) begin
			poll_cnt  <= '0;
			poll_tick <= 1'b0;
		end else begin
			poll_tick <= (poll_cnt == 16'(ims_pkg::POLL_CYC - 1));
			poll_cnt  <= (poll_cnt == 16'(ims_pkg::POLL_CYC - 1)) ? '0 : poll_cnt + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transfer sequencer
	always_ff @(posedge clock) begin
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		done   <= 1'b0;
		if (!rstn) begin
			state     <= IDLE;
			phase     <= ims_pkg::PH_START;
			cmd_ready <= 1'b1;
			done_err  <= 3'h0;
			rd_mode   <= 1'b0;
			addr      <= 7'h00;
			rem       <= '0;
			reg_addr  <= ims_pkg::REG_CR;
			reg_wdata <= ims_pkg::CR_RST;
		end else begin
			unique case (state)
				IDLE: if (cmd_valid) begin
					cmd_ready <= 1'b0;
					rd_mode   <= cmd_read;
					addr      <= cmd_addr;
					rem       <= (cmd_len == '0) ? LW'(1) : cmd_len;
					done_err  <= 3'h0;
					state     <= EN1;
				end
				// First write only sets the enable, second one takes the rest
				EN1: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR; reg_wdata <= cr_pe;
					state  <= EN2;
				end
				EN2: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR; reg_wdata <= cr_base | cr_ack;
					state  <= BUSY_RD;
				end
				BUSY_RD: begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_SR1;
					state  <= BUSY_CHK;
				end
				BUSY_CHK: state <= busy ? BUSY_RD : START;
				START: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR;
					reg_wdata <= cr_base | cr_ack | cr_start;
					phase  <= ims_pkg::PH_START;
					state  <= POLL_WAIT;
				end
				// Status-one read opens every access pair
				POLL_WAIT: if (irq_s || poll_tick) begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_SR1;
					state  <= POLL_CHK;
				end
				POLL_CHK: begin
					if (!event_flag)
						state <= POLL_WAIT;
					else if (sb)
						state <= ADDR_WR;
					else if (byte_finished_flag && phase == ims_pkg::PH_DATA)
						state <= rd_mode ? RX_CR : TX_WR;
					else
						state <= SR2_RD;
				end
				SR2_RD: begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_SR2;
					state  <= SR2_CHK;
				end
				SR2_CHK: begin
					if (errs != 3'h0) begin
						done_err <= errs;
						state    <= REL_SET;
					end else if (phase == ims_pkg::PH_ADDR)
						state <= EV6_RD;
					else
						state <= POLL_WAIT;
				end
				ADDR_WR: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_DR;
					reg_wdata <= {addr, rd_mode};
					phase  <= ims_pkg::PH_ADDR;
					state  <= POLL_WAIT;
				end
				EV6_RD: begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_SR1;
					state  <= EV6_WR;
				end
				// Single byte reads lose the acknowledge before the data arrives
				EV6_WR: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR;
					reg_wdata <= (rd_mode && last_rx) ? cr_base : (cr_base | cr_ack);
					phase  <= ims_pkg::PH_DATA;
					state  <= rd_mode ? POLL_WAIT : TX_RD;
				end
				TX_RD: begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_SR1;
					state  <= TX_WR;
				end
				// Stalls with the clock stretched while the FIFO is empty
				TX_WR: if (tx_out.valid) begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_DR;
					reg_wdata <= tx_out.data;
					rem    <= rem - LW'(1);
					state  <= last_rx ? TX_STOP : POLL_WAIT;
				end
				TX_STOP: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR;
					reg_wdata <= cr_base | cr_ack | cr_stop;
					phase  <= ims_pkg::PH_END;
					state  <= END_WAIT;
				end
				RX_CR: begin
					if (rem_two || last_rx) begin
						reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR;
						reg_wdata <= last_rx ? (cr_base | cr_stop) : cr_base;
					end
					state <= RX_RD;
				end
				// Data read waits for room so no byte is dropped
				RX_RD: if (rx_in.ready) begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_DR;
					state  <= RX_CAP;
				end
				RX_CAP: begin
					rem   <= rem - LW'(1);
					phase <= last_rx ? ims_pkg::PH_END : phase;
					state <= last_rx ? END_WAIT : POLL_WAIT;
				end
				// Release the lines after an error: set then clear the stop request
				REL_SET: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR;
					reg_wdata <= cr_base | cr_ack | cr_stop;
					state  <= REL_CLR;
				end
				REL_CLR: begin
					reg_wr <= 1'b1; reg_addr <= ims_pkg::REG_CR;
					reg_wdata <= cr_base | cr_ack;
					state  <= DONE;
				end
				END_WAIT: if (poll_tick) begin
					reg_rd <= 1'b1; reg_addr <= ims_pkg::REG_SR1;
					state  <= END_CHK;
				end
				END_CHK: state <= msl ? END_WAIT : DONE;
				DONE: begin
					done      <= 1'b1;
					cmd_ready <= 1'b1;
					state     <= IDLE;
				end
			endcase
		end
	end
endmodule : ims_master_seq

//--- tb/ims_master_seq_props.sv
// Port checker for the master sequencer
`timescale 1ns/100ps
module ims_master_seq_props (
	input wire logic       clock,
	input wire logic       rstn,
	input wire logic       cmd_valid,
	input wire logic       cmd_ready,
	input wire logic       done,
	input wire logic [2:0] done_err,
	input wire logic [1:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	logic       pair;
	logic [1:0] st;
	wire        s1_rd  = reg_rd && reg_addr == ims_pkg::REG_SR1;
	wire        dr_acc = (reg_rd || reg_wr) && reg_addr == ims_pkg::REG_DR;
	wire        st_wr  = reg_wr && reg_addr == ims_pkg::REG_CR && reg_wdata[ims_pkg::CR_START];
	////////////////////////////////////////////////////////////
	// Last status one read: pending pair, busy and master bits
	always_ff @(posedge clock) begin
		pair <= rstn && (s1_rd || pair && !dr_acc);
		st   <= !rstn ? 2'h0 : s1_rd ? {reg_rdata[ims_pkg::SR1_BUSY], reg_rdata[ims_pkg::SR1_MSL]} : st;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	property p_excl; !(reg_rd && reg_wr); endproperty
	a_excl: assert property (p_excl) else $error("read and write strobes together");
	property p_take; s_take |=> !cmd_ready; endproperty
	a_take: assert property (p_take) else $error("ready kept after a command was taken");
	property p_done_pulse; done |=> !done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	property p_done_ready; done |=> cmd_ready; endproperty
	a_done_ready: assert property (p_done_ready) else $error("not ready after done");
	property p_dr_wr; reg_wr && reg_addr == ims_pkg::REG_DR |-> pair; endproperty
	a_dr_wr: assert property (p_dr_wr) else $error("data write without status read");
	property p_dr_rd; reg_rd && reg_addr == ims_pkg::REG_DR |-> pair; endproperty
	a_dr_rd: assert property (p_dr_rd) else $error("data read without status read");
	property p_start; st_wr && !st[0] |-> !st[1]; endproperty
	a_start: assert property (p_start) else $error("start requested on a busy bus");
	property p_end; done && done_err == 3'h0 |-> !st[0]; endproperty
	a_end: assert property (p_end) else $error("done while still master");
endmodule : ims_master_seq_props

//--- tb/ims_dev_model.sv
// Register model of the I2C interface with a slave behind it
`timescale 1ns/100ps
module ims_dev_model (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic [1:0] reg_addr,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	output logic            dev_irq,
	input  wire logic [7:0] lat,
	input  wire logic       nack
);
	logic [7:0]  cr, dr, sr2, cnt, nrx, adr;
	logic [15:0] acks;
	logic [2:0]  pend;
	logic        event_flag, sb, byte_finished_flag, msl, arm, err;
	logic [7:0]  txlog[$];
	wire         ws  = reg_wr && reg_addr == ims_pkg::REG_CR;
	wire         wd  = reg_wr && reg_addr == ims_pkg::REG_DR;
	wire         rd  = reg_rd && reg_addr == ims_pkg::REG_DR;
	wire         stp = cr[ims_pkg::CR_STOP];
	wire [7:0]   sr1 = {event_flag, 2'h0, msl, byte_finished_flag, 1'b0, msl, sb};
	////////////////////////////////////////////////////////////
	// Read data stands in the cycle of the read strobe, as the sequencer samples it there
	assign reg_rdata = !reg_rd ? 8'hff :
		(reg_addr == ims_pkg::REG_SR1) ? sr1 :
		(reg_addr == ims_pkg::REG_SR2) ? sr2 :
		(reg_addr == ims_pkg::REG_DR) ? dr : cr;
	////////////////////////////////////////////////////////////
	// One request for all events, gated by the enable bit
	assign dev_irq = event_flag && cr[ims_pkg::CR_ITE];
	// Transfer timer, register reads and the flag clearing pairs
	always @(posedge clock) begin
		if (!rstn) begin
			{cr, sr2, pend} <= '0;
			{event_flag, sb, byte_finished_flag, msl, arm, err} <= '0;
		end else begin
			if (pend != 3'h0) cnt <= cnt - 8'h01;
			if (pend != 3'h0 && cnt == 8'h00) begin
				pend <= 3'h0;
				case (pend)
					3'h1: {event_flag, sb, cr[ims_pkg::CR_START]} <= 3'b110;
					3'h2: {event_flag, err, sr2[ims_pkg::SR2_AF]} <= {1'b1, nack, nack};
					3'h4: {msl, cr[ims_pkg::CR_STOP]} <= 2'b00;
					default: begin
						if (!adr[0] && stp) {msl, cr[ims_pkg::CR_STOP]} <= 2'b00;
						else {event_flag, byte_finished_flag, dr, nrx, acks} <= {2'b11, 8'ha0 + nrx, nrx + 8'h01, acks[14:0], cr[ims_pkg::CR_ACK]};
					end
				endcase
			end
			if (reg_rd && reg_addr == ims_pkg::REG_SR1) arm <= 1'b1;
			if (reg_rd && reg_addr == ims_pkg::REG_SR2) begin
				sr2 <= 8'h00;
				event_flag <= event_flag && sr2 == 8'h00;
			end
			if (wd && arm) begin
				{sb, event_flag, byte_finished_flag, arm} <= '0;
				pend <= sb ? 3'h2 : 3'h3;
				cnt <= lat;
				if (sb) {adr, acks, nrx} <= {reg_wdata, 24'h0};
				else txlog.push_back(reg_wdata);
			end
			if (rd && arm && byte_finished_flag) begin
				{event_flag, byte_finished_flag, arm} <= '0;
				pend <= stp ? 3'h4 : 3'h3;
				cnt <= lat;
			end
			if (ws) begin
				cr <= reg_wdata[ims_pkg::CR_PE] ? reg_wdata : reg_wdata & 8'h02;
				if (!reg_wdata[ims_pkg::CR_PE]) {event_flag, sb, byte_finished_flag, msl, sr2} <= '0;
				else if (reg_wdata[ims_pkg::CR_START] && !msl) {msl, pend, cnt} <= {4'h9, lat};
				else if (reg_wdata[ims_pkg::CR_STOP] && err) {msl, err, event_flag} <= '0;
				else if (arm && event_flag && !sb && !byte_finished_flag) {event_flag, arm, pend, cnt} <= {2'b00, adr[0] ? 3'h3 : 3'h0, lat};
			end
		end
	end
endmodule : ims_dev_model

//--- tb/tb_i2c_master_event_sequencer.sv
// Testbench for the master event sequencer
`timescale 1ns/100ps
`define CHK(got, exp) begin \
	check_count++; \
	if ((got) !== (exp)) begin \
		miscompares++; \
		$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
	end \
end
module tb_i2c_master_event_sequencer;
	logic       clock = 1'b0;
	logic       rstn = 1'b0;
	logic       cmd_valid, cmd_ready, cmd_read, tx_valid, tx_ready, rx_valid, rx_ready, done, reg_wr, reg_rd, dev_irq, nack;
	logic [6:0] cmd_addr;
	logic [7:0] cmd_len, tx_data, rx_data, reg_wdata, reg_rdata, lat;
	logic [2:0] done_err;
	logic [1:0] reg_addr;
	int         miscompares, check_count, cycles;
	ims_master_seq u_dut (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .done(done),
		.done_err(done_err), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .dev_irq(dev_irq));
	ims_dev_model u_dev (.clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dev_irq(dev_irq), .lat(lat), .nack(nack));
	////////////////////////////////////////////////////////////
	// Clock and cycle ceiling
	always #2.5 clock = ~clock;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// Queue one byte; valid stays up for the next call
	task automatic push(input logic [7:0] d);
		@(posedge clock);
		{tx_valid, tx_data} <= {1'b1, d};
		@(negedge clock);
		while (tx_ready !== 1'b1) @(negedge clock);
	endtask : push
	// Issue one command, wait for its end and check the outcome
	task automatic run_cmd(input logic rd, input logic [6:0] a, input logic [7:0] n, input logic nk, input logic [2:0] e);
		@(posedge clock);
		{cmd_valid, cmd_read, cmd_addr, cmd_len, nack} <= {1'b1, rd, a, n, nk};
		@(negedge clock);
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(posedge clock);
		cmd_valid <= 1'b0;
		while (done !== 1'b1) @(negedge clock);
		`CHK(done_err, e)
		`CHK(u_dev.msl, 1'b0)
	endtask : run_cmd
	// Test sequence
	initial begin
		{cmd_valid, cmd_read, tx_valid, rx_ready, nack, cmd_addr, cmd_len, tx_data} = '0;
		lat = 8'h06;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		@(negedge clock);
		`CHK({cmd_ready, tx_ready, rx_valid, done, reg_wr, reg_rd}, 6'b110000)
		// Refused address; the queued byte must survive
		push(8'h55);
		@(posedge clock);
		tx_valid <= 1'b0;
		run_cmd(1'b0, 7'h11, 8'h01, 1'b1, 3'b100);
		// Fill the transmit queue until refused, then send all of it
		for (int i = 1; i < 16; i++) push(i[7:0]);
		@(posedge clock);
		tx_valid <= 1'b0;
		@(negedge clock);
		`CHK(tx_ready, 1'b0)
		run_cmd(1'b0, 7'h2a, 8'h10, 1'b0, 3'b000);
		`CHK(u_dev.adr, 8'h54)
		`CHK(u_dev.txlog.size(), 16)
		for (int i = 0; i < 16; i++) `CHK(u_dev.txlog[i], i == 0 ? 8'h55 : i[7:0])
		// Slow receive of 16 bytes with the reader stalled
		@(posedge clock);
		lat <= 8'h28;
		run_cmd(1'b1, 7'h2b, 8'h10, 1'b0, 3'b000);
		`CHK(u_dev.acks, 16'hfffe)
		@(posedge clock);
		rx_ready <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(negedge clock);
			`CHK({rx_valid, rx_data}, {1'b1, 8'ha0 + i[7:0]})
			@(posedge clock);
		end
		rx_ready <= 1'b0;
		@(negedge clock);
		`CHK(rx_valid, 1'b0)
		// Single byte receive: that byte is not acknowledged
		run_cmd(1'b1, 7'h2b, 8'h01, 1'b0, 3'b000);
		`CHK(u_dev.acks[0], 1'b0)
		`CHK(rx_data, 8'ha0)
		stop_test();
	end
endmodule : tb_i2c_master_event_sequencer
bind ims_master_seq ims_master_seq_props u_props (.clock(clock), .rstn(rstn), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .done(done), .done_err(done_err), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
